/* File: rtl/daisy_chain_interrupt_priority.sv */
// Interrupt priority daisy-chain logic with vector supply and return decode
// ==========================================================
// What this block does
// - Interrupt status does not change while the fetch-cycle marker is active, except on soft reset.
// - In acknowledge, pending device with chain in high and out low drives its vector.
// - Acknowledged device holds chain out low until return seen with chain in high.
// - Device decodes the two-byte return instruction itself from fetched opcodes.
// - Nothing pending or under service: chain out equals chain in.
// - Under service forces chain out low whatever chain in does.
// - Pending unacknowledged: chain out low; after prefix ED it follows chain in until next byte.
// - ED then 4D clears under service, only for chain in high, out low.
// - Fetch marker with read is an opcode fetch; data bus is sampled.
// - Fetch marker without read or I/O request resets the device.
`timescale 1ns/1ps
`default_nettype none

module daisy_chain_interrupt_priority
   import daisy_chain_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_reset_n,
   input  wire host_bus_t  i_bus,
   input  wire logic [7:0] i_vector,
   input  wire logic       i_interrupt_event,
   input  wire logic       i_priority_chain_in,
   output logic            o_priority_chain_out,
   output logic            o_int_request_out,
   output logic            o_int_request_oe,
   output bus_drive_t      o_data,
   output logic            o_pending,
   output logic            o_under_service
);

   // ==========================================================
   // Bus cycle decode
   logic marker;
   logic ack_now;
   logic soft_reset;
   logic prefix_seen;
   logic return_seen;

   assign marker     = ~i_bus.fetch_cycle_marker_n;
   assign ack_now    = marker & ~i_bus.io_request_n;
   assign soft_reset = marker & i_bus.read_n & i_bus.io_request_n;

   return_decoder u_return_decoder (
      .i_clk_sys               (i_clk_sys),
      .i_reset_n               (i_reset_n),
      .i_soft_reset            (soft_reset),
      .i_bus                   (i_bus),
      .o_prefix_seen           (prefix_seen),
      .o_return_from_interrupt (return_seen)
   );

   // ==========================================================
   // Interrupt status
   logic event_reg;
   logic event_next;
   logic pending_reg;
   logic pending_next;
   logic service_reg;
   logic service_next;
   logic ack_reg;
   logic ack_next;
   logic won_reg;
   logic won_next;
   logic ret_now;
   logic ret_reg;
   logic ret_next;

   always_comb begin
      event_next   = event_reg | i_interrupt_event;
      pending_next = pending_reg;
      service_next = service_reg;
      ack_next     = ack_now;
      won_next     = won_reg;
      // A return seen while the next fetch already holds the marker is kept, not lost
      ret_now      = ret_reg | (return_seen & i_priority_chain_in);
      ret_next     = ret_now;
      // Winner is fixed in the first acknowledge cycle, once the chain has settled
      if (ack_now && !ack_reg) begin
         won_next = pending_reg & i_priority_chain_in & ~o_priority_chain_out;
      end
      if (!marker) begin
         // Clears go first and sets last, so a set in the same cycle wins
         if (ret_now && service_reg) begin
            service_next = 1'b0;
         end
         ret_next = 1'b0;
         if (ack_reg && won_reg) begin
            pending_next = 1'b0;
            service_next = 1'b1;
            won_next     = 1'b0;
         end else if (ack_reg) begin
            won_next = 1'b0;
         end
         // Events arriving during the marker wait here instead of being lost
         if (event_reg) begin
            pending_next = 1'b1;
            event_next   = i_interrupt_event;
         end
      end
      if (soft_reset) begin
         event_next   = 1'b0;
         pending_next = 1'b0;
         service_next = 1'b0;
         won_next     = 1'b0;
         ret_next     = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         event_reg   <= 1'b0;
         pending_reg <= 1'b0;
         service_reg <= 1'b0;
         ack_reg     <= 1'b0;
         won_reg     <= 1'b0;
         ret_reg     <= 1'b0;
      end else begin
         event_reg   <= event_next;
         pending_reg <= pending_next;
         service_reg <= service_next;
         ack_reg     <= ack_next;
         won_reg     <= won_next;
         ret_reg     <= ret_next;
      end
   end

   // ==========================================================
   // Vector capture
   logic [7:0] vector_reg;
   logic [7:0] vector_next;

   always_comb begin
      vector_next = vector_reg;
      // Taken once per acknowledge, so a vector that moves mid-cycle cannot tear the bus
      if (ack_now && !ack_reg) begin
         vector_next = i_vector;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         vector_reg <= VECTOR_RESET;
      end else begin
         vector_reg <= vector_next;
      end
   end

   // ==========================================================
   // Chain output
   logic chain_out_reg;
   logic chain_out_next;

   always_comb begin
      // Built from the status registered at this edge, so it never lags the status
      if (service_next) begin
         chain_out_next = 1'b0;
      end else if (pending_next) begin
         chain_out_next = i_priority_chain_in & prefix_seen;
      end else begin
         chain_out_next = i_priority_chain_in;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         chain_out_reg <= 1'b0;
      end else begin
         chain_out_reg <= chain_out_next;
      end
   end

   // ==========================================================
   // Request pin
   logic int_oe_reg;
   logic int_oe_next;

   always_comb begin
      int_oe_next = pending_next & i_priority_chain_in;
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         int_oe_reg <= 1'b0;
      end else begin
         int_oe_reg <= int_oe_next;
      end
   end

   // ==========================================================
   // Vector drive
   bus_drive_t data_reg;
   bus_drive_t data_next;

   always_comb begin
      data_next.oe   = 1'b0;
      data_next.data = VECTOR_RESET;
      // Vector stands for the whole acknowledge cycle, then the bus is released
      if (ack_now && (won_next || won_reg)) begin
         data_next.oe   = 1'b1;
         data_next.data = vector_next;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         data_reg <= '{oe: 1'b0, data: VECTOR_RESET};
      end else begin
         data_reg <= data_next;
      end
   end

   assign o_priority_chain_out = chain_out_reg;
   assign o_int_request_out    = 1'b0;
   assign o_int_request_oe     = int_oe_reg;
   assign o_data               = data_reg;
   assign o_pending            = pending_reg;
   assign o_under_service      = service_reg;

endmodule

`default_nettype wire

/* File: rtl/daisy_chain_pkg.sv */
// Shared constants and bus carrier types for the interrupt daisy-chain block
package daisy_chain_pkg;

   // ==========================================================
   // Opcode bytes of the two-byte return instruction
   localparam logic [7:0] OPC_PREFIX_ED = 8'hed;
   localparam logic [7:0] OPC_RETURN_4D = 8'h4d;

   // ==========================================================
   // Values after reset
   localparam logic [7:0] VECTOR_RESET  = 8'h00;
   localparam logic [7:0] OPCODE_RESET  = 8'h00;

   // ==========================================================
   // Host bus strobes, all active low, sampled on i_clk_sys
   typedef struct packed {
      logic       fetch_cycle_marker_n;
      logic       read_n;
      logic       io_request_n;
      logic [7:0] data;
   } host_bus_t;

   // Data bus drive toward the host
   typedef struct packed {
      logic       oe;
      logic [7:0] data;
   } bus_drive_t;

endpackage

/* File: rtl/return_decoder.sv */
// Opcode fetch watcher that finds the prefix byte and the return-from-interrupt pair
`timescale 1ns/1ps
`default_nettype none

module return_decoder
   import daisy_chain_pkg::*;
(
   input  wire logic      i_clk_sys,
   input  wire logic      i_reset_n,
   input  wire logic      i_soft_reset,
   input  wire host_bus_t i_bus,
   output logic           o_prefix_seen,
   output logic           o_return_from_interrupt
);

   // ==========================================================
   // Fetch byte capture and decode
   logic       fetch_now;
   logic       fetch_reg;
   logic       fetch_next;
   logic [7:0] opcode_reg;
   logic [7:0] opcode_next;
   logic       prefix_reg;
   logic       prefix_next;
   logic       return_from_interrupt_reg;
   logic       return_from_interrupt_next;

   always_comb begin
      fetch_now   = ~i_bus.fetch_cycle_marker_n & ~i_bus.read_n;
      fetch_next  = fetch_now;
      opcode_next = fetch_now ? i_bus.data : opcode_reg;
      prefix_next = prefix_reg;
      return_from_interrupt_next   = 1'b0;
      // Decode once, when the fetch ends, so a stretched fetch counts as one byte
      if (fetch_reg && !fetch_now) begin
         prefix_next = (opcode_reg == OPC_PREFIX_ED);
         return_from_interrupt_next   = prefix_reg && (opcode_reg == OPC_RETURN_4D);
      end
      if (i_soft_reset) begin
         prefix_next = 1'b0;
         return_from_interrupt_next   = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fetch_reg  <= 1'b0;
         opcode_reg <= OPCODE_RESET;
         prefix_reg <= 1'b0;
         return_from_interrupt_reg   <= 1'b0;
      end else begin
         fetch_reg  <= fetch_next;
         opcode_reg <= opcode_next;
         prefix_reg <= prefix_next;
         return_from_interrupt_reg   <= return_from_interrupt_next;
      end
   end

   assign o_prefix_seen           = prefix_reg;
   assign o_return_from_interrupt = return_from_interrupt_reg;

endmodule

`default_nettype wire

/* File: testbench/daisy_chain_interrupt_priority_tb.sv */
// Self-checking bench for the interrupt daisy-chain block
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_interrupt_priority_tb
   import daisy_chain_pkg::*;
;
   logic       i_clk_sys, i_reset_n, i_interrupt_event, i_priority_chain_in;
   logic       o_priority_chain_out, o_int_request_out, o_int_request_oe;
   logic       o_pending, o_under_service;
   logic [7:0] i_vector, seen_vec;
   host_bus_t  bus;
   bus_drive_t o_data;
   int         n_mismatch = 0, cmp_count = 0, seed = 5930, pend = 0, svc = 0;
   host_cpu_model cpu (.i_clk_sys(i_clk_sys), .o_bus(bus));
   daisy_chain_interrupt_priority uut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .i_bus(bus), .i_vector(i_vector), .i_interrupt_event(i_interrupt_event),
      .i_priority_chain_in(i_priority_chain_in), .o_priority_chain_out(o_priority_chain_out),
      .o_int_request_out(o_int_request_out), .o_int_request_oe(o_int_request_oe),
      .o_data(o_data), .o_pending(o_pending), .o_under_service(o_under_service));
   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) if (o_data.oe === 1'b1) seen_vec <= o_data.data;
   task automatic chk(input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n); repeat (n) @(posedge i_clk_sys); #1; endtask
   task automatic ev(); @(posedge i_clk_sys); i_interrupt_event <= 1'b1;
      @(posedge i_clk_sys); i_interrupt_event <= 1'b0; endtask
   task automatic chain(input logic v); @(posedge i_clk_sys); i_priority_chain_in <= v;
      tick(2); endtask
   // Model: chain out mirrors chain in only while idle
   task automatic cmp_all();
      chk({7'h00, o_pending}, 8'(pend));
      chk({7'h00, o_under_service}, 8'(svc));
      chk({7'h00, o_int_request_oe}, 8'(pend & i_priority_chain_in));
      chk({7'h00, o_priority_chain_out}, 8'((pend | svc) == 0 ? i_priority_chain_in : 0));
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      n_mismatch++;
      print_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      i_reset_n = 1'b0;
      i_interrupt_event = 1'b0;
      i_priority_chain_in = 1'b1;
      i_vector = 8'h00;
      seen_vec = 8'h00;
      repeat (8) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         chain(k[0]);
         cmp_all();
      end
      $display("test follow done");
      i_vector <= 8'($random(seed));
      chain(1'b1);
      ev();
      tick(3);
      pend = 1;
      cmp_all();
      cpu.fetch(OPC_PREFIX_ED);
      tick(1);
      chk({7'h00, o_priority_chain_out}, 8'h01);
      cpu.fetch(8'($random(seed)) & 8'h3f);
      tick(1);
      cmp_all();
      $display("test prefix done");
      seen_vec = ~i_vector;
      cpu.ack();
      tick(2);
      pend = 0;
      svc = 1;
      chk(seen_vec, i_vector);
      chk({7'h00, o_data.oe}, 8'h00);
      chain(1'b0);
      cmp_all();
      cpu.fetch(OPC_PREFIX_ED);
      cpu.fetch(OPC_RETURN_4D);
      tick(3);
      cmp_all();
      chain(1'b1);
      cpu.fetch(OPC_PREFIX_ED);
      cpu.fetch(OPC_RETURN_4D);
      tick(3);
      svc = 0;
      cmp_all();
      $display("test acknowledge and return done");
      fork
         cpu.cycle(1'b0, 1'b0, 1'b1, 8'h00, 6);
         begin
            repeat (2) @(posedge i_clk_sys);
            ev();
            tick(2);
            chk({7'h00, o_pending}, 8'h00);
         end
      join
      tick(3);
      pend = 1;
      cmp_all();
      chain(1'b0);
      seen_vec = ~i_vector;
      cpu.ack();
      tick(2);
      chk(seen_vec, ~i_vector);
      cmp_all();
      cpu.soft_reset();
      tick(2);
      pend = 0;
      cmp_all();
      $display("test freeze and soft reset done");
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: testbench/daisy_chain_monitor.sv */
// Checker for the interrupt daisy-chain block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_monitor
   import daisy_chain_pkg::*;
(
   input wire logic       i_clk_sys,
   input wire logic       i_reset_n,
   input wire host_bus_t  i_bus,
   input wire logic [7:0] i_vector,
   input wire logic       i_priority_chain_in,
   input wire logic       o_priority_chain_out,
   input wire logic       o_int_request_out,
   input wire logic       o_int_request_oe,
   input wire bus_drive_t o_data,
   input wire logic       o_pending,
   input wire logic       o_under_service
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   logic fetch, ack, srst, run_reg;
   logic frz, idle;
   assign fetch = !i_bus.fetch_cycle_marker_n && !i_bus.read_n;
   assign ack = !i_bus.fetch_cycle_marker_n && !i_bus.io_request_n;
   assign srst = !i_bus.fetch_cycle_marker_n && i_bus.read_n && i_bus.io_request_n;
   assign frz = !i_bus.fetch_cycle_marker_n && !srst;
   assign idle = !o_pending && !o_under_service;
   // Masks the first edge after reset, where outputs still hold reset values
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= 1'b1;
      end
   end
   sequence s_op(b); fetch && i_bus.data == b ##1 !fetch; endsequence
   property p_freeze; run_reg && $past(frz)
      |-> $stable(o_pending) && $stable(o_under_service); endproperty
   a_freeze: assert property (p_freeze) else $error("status moved in fetch marker");
   property p_vector; ack && !$past(ack) && o_pending && i_priority_chain_in
      && !o_priority_chain_out |=> o_data.oe && o_data.data == $past(i_vector); endproperty
   a_vector: assert property (p_vector) else $error("vector not driven");
   property p_oe_cause; o_data.oe |-> $past(ack); endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("vector outside acknowledge");
   property p_return; (o_under_service && i_priority_chain_in) ##0 s_op(OPC_PREFIX_ED)
      ##[1:4] s_op(OPC_RETURN_4D) |-> ##[1:3] !o_under_service; endproperty
   a_return: assert property (p_return) else $error("return missed");
   property p_follow; run_reg && idle && $past(idle)
      |-> o_priority_chain_out == $past(i_priority_chain_in); endproperty
   a_follow: assert property (p_follow) else $error("chain out not following");
   property p_service_low; o_under_service |-> !o_priority_chain_out; endproperty
   a_service_low: assert property (p_service_low) else $error("chain out high in service");
   property p_prefix; (o_pending && !o_under_service && i_priority_chain_in)
      ##0 s_op(OPC_PREFIX_ED) |-> ##[1:3] o_priority_chain_out; endproperty
   a_prefix: assert property (p_prefix) else $error("prefix did not raise chain out");
   property p_soft_reset; srst |=> ##[0:1] (!o_pending && !o_under_service); endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset ignored");
   property p_request; o_int_request_oe |-> o_pending && !o_int_request_out; endproperty
   a_request: assert property (p_request) else $error("request without pending");
endmodule
bind daisy_chain_interrupt_priority daisy_chain_monitor mon (.i_clk_sys, .i_reset_n, .i_bus,
   .i_vector, .i_priority_chain_in, .o_priority_chain_out, .o_int_request_out,
   .o_int_request_oe, .o_data, .o_pending, .o_under_service);
`default_nettype wire

/* File: testbench/host_cpu_model.sv */
// Host CPU bus model issuing fetch, acknowledge and reset cycles
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
   import daisy_chain_pkg::*;
(
   input  wire logic i_clk_sys,
   output var host_bus_t o_bus
);
   initial o_bus = '{1'b1, 1'b1, 1'b1, 8'h00};
   // Released data bus shows the inverted byte so no stale value survives
   task automatic cycle(input logic m, r, io, input logic [7:0] d, input int n);
      @(posedge i_clk_sys);
      o_bus <= '{m, r, io, d};
      repeat (n) @(posedge i_clk_sys);
      o_bus <= '{1'b1, 1'b1, 1'b1, ~d};
      repeat (2) @(posedge i_clk_sys);
   endtask
   task automatic fetch(input logic [7:0] b); cycle(1'b0, 1'b0, 1'b1, b, 2); endtask
   task automatic ack(); cycle(1'b0, 1'b1, 1'b0, 8'hff, 3); endtask
   task automatic soft_reset(); cycle(1'b0, 1'b1, 1'b1, 8'hff, 1); endtask
endmodule
`default_nettype wire
